// *** bench/cca_sva.sv ***
// Port-level assertions for the calendar clock unit
`timescale 1ns/100ps
`default_nettype none
module cca_sva
  import cca_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic [11:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic calendar_pin_oe_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_b_i);
  // ****************************************
  // Address decode and bus phases
  // ****************************************
  logic mapped;
  assign mapped = (paddr_i[11:4] >= CCA_CTRL_OFS[11:4]) &&
    (paddr_i[11:4] <= CCA_ALM_DATE_OFS[11:4]) && (paddr_i[1:0] == 2'h0);
  sequence s_setup;
    psel_i && !penable_i;
  endsequence
  sequence s_access;
    psel_i && penable_i;
  endsequence
  // ****************************************
  // Assertions
  // ****************************************
  a_ready_in_access: assert property (s_setup ##1 s_access |-> pready_o)
    else $error("access phase without ready");
  a_err_mapped: assert property (psel_i && penable_i && mapped |-> !pslverr_o)
    else $error("error on a mapped register");
  a_err_unmapped: assert property (psel_i && penable_i && !mapped |-> pslverr_o)
    else $error("no error on an unmapped address");
  a_err_outside: assert property (pslverr_o |-> psel_i && penable_i)
    else $error("error outside an access phase");
  // Read data may only move when a read setup is taken
  a_read_hold: assert property (!(psel_i && !penable_i && !pwrite_i) |=> $stable(prdata_o))
    else $error("read data moved without a read");
  a_read_unmapped: assert property (s_setup ##0 (!pwrite_i && !mapped) |=> prdata_o == '0)
    else $error("unmapped read not zero");
  a_oe_after_reset: assert property ($rose(rst_b_i) |-> !calendar_pin_oe_o [*2])
    else $error("pin enabled after reset");
  a_oe_by_write: assert property ($changed(calendar_pin_oe_o) |->
    $past(psel_i && penable_i && pwrite_i))
    else $error("pin enable moved without a write");
endmodule
bind cca_calendar_clock_alarm cca_sva sva_u (
  .clk_sys_i(clk_sys_i),
  .rst_b_i(rst_b_i),
  .paddr_i(paddr_i),
  .psel_i(psel_i),
  .penable_i(penable_i),
  .pwrite_i(pwrite_i),
  .prdata_o(prdata_o),
  .pready_o(pready_o),
  .pslverr_o(pslverr_o),
  .calendar_pin_oe_o(calendar_pin_oe_o)
);
`default_nettype wire

// *** bench/testbench.sv ***
// Self-checking bench for the calendar clock unit
`timescale 1ns/100ps
`default_nettype none
module testbench
  import cca_pkg::*;
;
  // Short half-second keeps the run brief; every expectation uses it
  localparam int HT = 4;
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  logic clk_sys_i, rst_b_i, psel_i, penable_i, pwrite_i, timebase_clk_i, cpu_idle_i;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, rd;
  logic pready_o, pslverr_o, calendar_pin_o, calendar_pin_oe_o, err;
  int mismatches = 0;
  int checks = 0;
  cca_calendar_clock_alarm #(.HALF_TICKS(HT)) dut_u (
    .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .paddr_i(paddr_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .timebase_clk_i(timebase_clk_i),
    .cpu_idle_i(cpu_idle_i), .calendar_pin_o(calendar_pin_o),
    .calendar_pin_oe_o(calendar_pin_oe_o));
  initial
  begin
    clk_sys_i = 1'h0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    psel_i <= 1'h1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_sys_i);
    penable_i <= 1'h1;
    do @(posedge clk_sys_i); while (pready_o !== 1'h1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'h0;
    penable_i <= 1'h0;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rdc(input string n, input logic [11:0] a, input logic [31:0] m, e);
    apb(1'h0, a, 32'h0000_0000);
    chk(n, e, rd & m);
  endtask
  // Each tick is long enough for the synchroniser to see both levels
  task automatic ticks(input int n);
    repeat (n)
    begin
      timebase_clk_i <= 1'h1;
      repeat (4) @(posedge clk_sys_i);
      timebase_clk_i <= 1'h0;
      repeat (4) @(posedge clk_sys_i);
    end
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset_map;
    rdc("ctrl reset", CCA_CTRL_OFS, ALL, 32'h0000_0000);
    rdc("alarm reset", CCA_ALM_CTRL_OFS, ALL, 32'h0000_0000);
    rdc("unmapped read", 12'h300, ALL, 32'h0000_0000);
    chk("unmapped error", 32'h0000_0001, {31'h0, err});
    apb(1'h1, CCA_TIME_OFS, 32'h1111_1100);
    rdc("locked time", CCA_TIME_OFS, ALL, 32'h0000_0000);
    apb(1'h1, CCA_CTRL_OFS, 32'h0000_8000);
    rdc("locked enable", CCA_CTRL_OFS, 32'h0000_8000, 32'h0000_0000);
  endtask
  task automatic t_alias;
    apb(1'h1, CCA_ALM_TIME_OFS, 32'h1234_5600);
    apb(1'h1, CCA_ALM_TIME_OFS + 12'h8, 32'h0001_0000);
    rdc("alias set", CCA_ALM_TIME_OFS, ALL, 32'h1235_5600);
    apb(1'h1, CCA_ALM_TIME_OFS + 12'h4, 32'h1000_0000);
    rdc("alias clear", CCA_ALM_TIME_OFS, ALL, 32'h0235_5600);
    apb(1'h1, CCA_ALM_TIME_OFS + 12'hC, 32'h0000_0300);
    rdc("alias invert", CCA_ALM_TIME_OFS, ALL, 32'h0235_5500);
  endtask
  task automatic t_rollover;
    apb(1'h1, CCA_CTRL_OFS, 32'h0000_0008);
    apb(1'h1, CCA_TIME_OFS, 32'h2359_5900);
    apb(1'h1, CCA_DATE_OFS, 32'h2402_2803);
    apb(1'h1, CCA_CTRL_OFS, 32'h0000_8089);
    ticks(HT);
    rdc("half flag", CCA_CTRL_OFS, 32'h0000_0002, 32'h0000_0002);
    chk("pin high", 32'h0000_0001, {31'h0, calendar_pin_o});
    chk("pin enable", 32'h0000_0001, {31'h0, calendar_pin_oe_o});
    ticks(HT);
    rdc("midnight", CCA_TIME_OFS, ALL, 32'h0000_0000);
    rdc("leap day", CCA_DATE_OFS, ALL, 32'h2402_2904);
    chk("pin low", 32'h0000_0000, {31'h0, calendar_pin_o});
    apb(1'h1, CCA_TIME_OFS, 32'h2359_5900);
    apb(1'h1, CCA_DATE_OFS, 32'h2302_2803);
    ticks(2 * HT);
    rdc("march first", CCA_DATE_OFS, ALL, 32'h2303_0104);
  endtask
  task automatic t_run_gate;
    apb(1'h1, CCA_CTRL_OFS, 32'h0000_0008);
    ticks(2 * HT);
    rdc("disabled", CCA_TIME_OFS, ALL, 32'h0000_0000);
    apb(1'h1, CCA_CTRL_OFS, 32'h0000_A008);
    cpu_idle_i <= 1'h1;
    ticks(2 * HT);
    rdc("idle halt", CCA_TIME_OFS, ALL, 32'h0000_0000);
    cpu_idle_i <= 1'h0;
    ticks(2 * HT);
    rdc("idle left", CCA_TIME_OFS, ALL, 32'h0000_0100);
  endtask
  task automatic t_alarm;
    apb(1'h1, CCA_TIME_OFS, 32'h0000_0000);
    apb(1'h1, CCA_ALM_CTRL_OFS, 32'h0000_8001);
    ticks(HT);
    rdc("repeat down", CCA_ALM_CTRL_OFS, 32'h0000_80FF, 32'h0000_8000);
    ticks(HT);
    rdc("alarm off", CCA_ALM_CTRL_OFS, 32'h0000_80FF, 32'h0000_0000);
    apb(1'h1, CCA_ALM_CTRL_OFS, 32'h0000_C000);
    ticks(HT);
    rdc("chime wrap", CCA_ALM_CTRL_OFS, 32'h0000_C0FF, 32'h0000_C0FF);
    apb(1'h1, CCA_ALM_CTRL_OFS, 32'h0000_8A00);
    ticks(2 * HT);
    rdc("reserved mask", CCA_ALM_CTRL_OFS, 32'h0000_8FFF, 32'h0000_8A00);
    apb(1'h1, CCA_TIME_OFS, 32'h0000_0000);
    apb(1'h1, CCA_ALM_CTRL_OFS, 32'h0000_8101);
    ticks(HT);
    rdc("second mask half", CCA_ALM_CTRL_OFS, 32'h0000_80FF, 32'h0000_8001);
    ticks(HT);
    rdc("second mask", CCA_ALM_CTRL_OFS, 32'h0000_80FF, 32'h0000_8000);
  endtask
  // Disarm first: the initial pulse level is frozen while the alarm is armed
  task automatic t_pulse;
    apb(1'h1, CCA_ALM_CTRL_OFS, 32'h0000_0000);
    apb(1'h1, CCA_ALM_CTRL_OFS, 32'h0000_2000);
    rdc("pulse level", CCA_ALM_CTRL_OFS, 32'h0000_2000, 32'h0000_2000);
    chk("pin pulse high", 32'h0000_0001, {31'h0, calendar_pin_o});
    apb(1'h1, CCA_ALM_CTRL_OFS, 32'h0000_A001);
    ticks(HT);
    rdc("pulse toggled", CCA_ALM_CTRL_OFS, 32'h0000_20FF, 32'h0000_0000);
    chk("pin pulse low", 32'h0000_0000, {31'h0, calendar_pin_o});
  endtask
  // A minute boundary preloads the calibration into the half-second count
  task automatic t_cal;
    apb(1'h1, CCA_CTRL_OFS, 32'h0001_A008);
    apb(1'h1, CCA_TIME_OFS, 32'h0000_5900);
    ticks(2 * HT);
    ticks(HT - 1);
    rdc("cal plus", CCA_CTRL_OFS, 32'h0000_0002, 32'h0000_0002);
    apb(1'h1, CCA_CTRL_OFS, 32'h03FF_A008);
    apb(1'h1, CCA_TIME_OFS, 32'h0000_5900);
    ticks(3 * HT);
    rdc("cal minus early", CCA_CTRL_OFS, 32'h0000_0002, 32'h0000_0000);
    ticks(1);
    rdc("cal minus", CCA_CTRL_OFS, 32'h0000_0002, 32'h0000_0002);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial
  begin
    rst_b_i = 1'h0;
    psel_i = 1'h0;
    penable_i = 1'h0;
    pwrite_i = 1'h0;
    paddr_i = 12'h000;
    pwdata_i = 32'h0000_0000;
    timebase_clk_i = 1'h0;
    cpu_idle_i = 1'h0;
    repeat (10) @(posedge clk_sys_i);
    rst_b_i <= 1'h1;
    t_reset_map();
    t_alias();
    t_rollover();
    t_run_gate();
    t_alarm();
    t_pulse();
    t_cal();
    summarize();
  end
  // Run needs well under a tenth of this span
  initial
  begin
    #200000;
    mismatches++;
    summarize();
  end
endmodule
`default_nettype wire

// *** src/cca_calendar_clock_alarm.sv ***
// Calendar clock unit: BCD time, calendar, alarm, calibration, APB registers
`timescale 1ns/100ps
`default_nettype none
module cca_calendar_clock_alarm
  import cca_pkg::*;
#(
  parameter int HALF_TICKS = CCA_HALF_TICKS
)
(
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic [11:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic timebase_clk_i,
  input wire logic cpu_idle_i,
  output logic calendar_pin_o,
  output logic calendar_pin_oe_o
);
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] alias_apply(input logic [31:0] old, input logic [31:0] wd,
                                              input logic [1:0] op);
    case (op)
      CCA_OP_CLR: alias_apply = old & ~wd;
      CCA_OP_SET: alias_apply = old | wd;
      CCA_OP_INV: alias_apply = old ^ wd;
      default: alias_apply = wd;
    endcase
  endfunction

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9)
    begin
      bcd_inc = {v[7:4] + 4'h1, 4'h0};
    end
    else
    begin
      bcd_inc = {v[7:4], v[3:0] + 4'h1};
    end
  endfunction

  // Leap years in 2000-2099 are exactly the multiples of four
  function automatic logic [7:0] days_in_month(input logic [7:0] mon, input logic [7:0] yr);
    logic leap;
    leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                 : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
    case (mon)
      8'h02: days_in_month = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: days_in_month = 8'h30;
      default: days_in_month = 8'h31;
    endcase
  endfunction

  // ****************************************
  // Registers
  // ****************************************
  localparam logic signed [15:0] PRESC_LAST = 16'(HALF_TICKS - 1);
  localparam logic signed [15:0] PRESC_WARN = 16'(HALF_TICKS - 1 - CCA_WARN_TICKS);

  logic [31:0] ctrl_r;
  logic [31:0] ctrl_nxt;
  logic [31:0] alm_r;
  logic [31:0] alm_nxt;
  logic [31:0] time_r;
  logic [31:0] time_nxt;
  logic [31:0] date_r;
  logic [31:0] date_nxt;
  logic [31:0] alm_time_r;
  logic [31:0] alm_date_r;
  logic signed [15:0] presc_r;
  logic signed [15:0] presc_nxt;
  logic half_r;
  logic alm_chk_r;
  logic pulse_r;
  logic pin_r;
  logic [31:0] prdata_r;
  logic tb_s1_r;
  logic tb_s2_r;
  logic tb_s3_r;

  // ****************************************
  // APB decode
  // ****************************************
  wire [1:0] op = paddr_i[3:2];
  wire aligned = (paddr_i[1:0] == 2'h0);
  wire hit_ctrl = aligned && paddr_i[11:4] == CCA_CTRL_OFS[11:4];
  wire hit_alm = aligned && paddr_i[11:4] == CCA_ALM_CTRL_OFS[11:4];
  wire hit_time = aligned && paddr_i[11:4] == CCA_TIME_OFS[11:4];
  wire hit_date = aligned && paddr_i[11:4] == CCA_DATE_OFS[11:4];
  wire hit_atime = aligned && paddr_i[11:4] == CCA_ALM_TIME_OFS[11:4];
  wire hit_adate = aligned && paddr_i[11:4] == CCA_ALM_DATE_OFS[11:4];
  wire hit_any = hit_ctrl | hit_alm | hit_time | hit_date | hit_atime | hit_adate;
  wire wr_acc = psel_i & penable_i & pwrite_i & hit_any;
  wire rd_setup = psel_i & ~penable_i & ~pwrite_i;
  wire unlock = ctrl_r[CCA_UNLOCK_BIT];
  wire wr_ctrl = wr_acc & hit_ctrl;
  wire wr_alm = wr_acc & hit_alm;
  wire wr_time = wr_acc & hit_time & unlock; // [RQ18]
  wire wr_date = wr_acc & hit_date & unlock; // [RQ18]
  wire wr_atime = wr_acc & hit_atime;
  wire wr_adate = wr_acc & hit_adate;

  // ****************************************
  // Timebase and prescaler
  // ****************************************
  wire tick = tb_s2_r & ~tb_s3_r;
  wire on = ctrl_r[CCA_ON_BIT];
  wire run = on & ~(ctrl_r[CCA_HALT_IDLE_BIT] & cpu_idle_i); // [RQ12] [RQ13]
  wire half_evt = run & tick & (presc_r == PRESC_LAST);
  wire sec_step = half_evt & half_r;
  wire roll_warn = run & (presc_r >= PRESC_WARN);
  wire [9:0] cal = ctrl_r[CCA_CAL_LSB +: 10];
  // Sign-extended preload: positive starts ahead (adds pulses), negative behind
  wire signed [15:0] cal_sext = {{6{cal[9]}}, cal}; // [RQ9] [RQ10] [RQ11] [RQ16]
  // Writing the seconds restarts the second so software aligns it exactly
  wire sec_write = wr_time & (pwdata_i[14:8] != 7'h00 | op == CCA_OP_WRITE);

  // ****************************************
  // Time of day counting
  // ****************************************
  wire [7:0] sec8 = {1'b0, time_r[14:8]};
  wire [7:0] min8 = {1'b0, time_r[22:16]};
  wire [7:0] hr8 = {2'b00, time_r[29:24]};
  wire sec_wrap = (sec8 >= 8'h59);
  wire min_wrap = (min8 >= 8'h59);
  wire hr_wrap = (hr8 >= 8'h23); // [RQ1]
  wire [7:0] sec_n = sec_wrap ? 8'h00 : bcd_inc(sec8); // [RQ4]
  wire [7:0] min_n = !sec_wrap ? min8 : (min_wrap ? 8'h00 : bcd_inc(min8)); // [RQ21]
  wire [7:0] hr_n = !(sec_wrap & min_wrap) ? hr8 : (hr_wrap ? 8'h00 : bcd_inc(hr8)); // [RQ1]
  wire day_carry = sec_wrap & min_wrap & hr_wrap; // [RQ21]
  wire min_edge = sec_step & sec_wrap;
  wire [31:0] time_adv = {2'b00, hr_n[5:0], 1'b0, min_n[6:0], 1'b0, sec_n[6:0], 8'h00};

  // ****************************************
  // Calendar counting
  // ****************************************
  wire [7:0] day8 = {2'b00, date_r[13:8]};
  wire [7:0] mon8 = {3'b000, date_r[20:16]};
  wire [7:0] yr8 = date_r[31:24];
  wire [2:0] wday = date_r[2:0];
  wire day_wrap = (day8 >= days_in_month(mon8, yr8)); // [RQ3]
  wire mon_wrap = (mon8 >= 8'h12);
  wire yr_wrap = (yr8 >= 8'h99); // [RQ3]
  wire [7:0] day_n = day_wrap ? 8'h01 : bcd_inc(day8);
  wire [7:0] mon_n = !day_wrap ? mon8 : (mon_wrap ? 8'h01 : bcd_inc(mon8)); // [RQ21]
  wire [7:0] yr_n = !(day_wrap & mon_wrap) ? yr8 : (yr_wrap ? 8'h00 : bcd_inc(yr8));
  wire [2:0] wday_n = (wday >= 3'h6) ? 3'h0 : wday + 3'h1;
  wire [31:0] date_adv = {yr_n, 3'b000, mon_n[4:0], 2'b00, day_n[5:0], 5'b00000, wday_n};

  // ****************************************
  // Alarm match
  // ****************************************
  wire [3:0] alarm_interval_mask = alm_r[CCA_ALARM_INTERVAL_MASK_LSB +: 4];
  wire alm_en = alm_r[CCA_ALM_EN_BIT];
  wire new_sec = ~half_r;
  wire m_su = time_r[11:8] == alm_time_r[11:8];
  wire m_s = time_r[14:8] == alm_time_r[14:8];
  wire m_mu = time_r[19:16] == alm_time_r[19:16];
  wire m_m = time_r[22:16] == alm_time_r[22:16];
  wire m_h = time_r[29:24] == alm_time_r[29:24];
  wire m_d = date_r[13:8] == alm_date_r[13:8];
  wire m_mo = date_r[20:16] == alm_date_r[20:16];
  wire m_w = date_r[2:0] == alm_date_r[2:0];
  wire m_hms = new_sec & m_s & m_m & m_h;
  logic match;

  always_comb
  begin
    case (alarm_interval_mask) // [RQ5] [RQ19]
      4'h0: match = 1'b1;
      4'h1: match = new_sec;
      4'h2: match = new_sec & m_su;
      4'h3: match = new_sec & m_s;
      4'h4: match = new_sec & m_s & m_mu;
      4'h5: match = new_sec & m_s & m_m;
      4'h6: match = m_hms;
      4'h7: match = m_hms & m_w;
      4'h8: match = m_hms & m_d;
      4'h9: match = m_hms & m_d & m_mo;
      default: match = 1'b0;
    endcase
  end

  wire alarm_evt = alm_chk_r & alm_en & match & run;

  // ****************************************
  // Next-state of software registers
  // ****************************************
  wire [31:0] ctrl_w = alias_apply(ctrl_r, pwdata_i, op) & CCA_CTRL_WMASK; // [RQ14]
  // Enable bit keeps its value unless the value registers are unlocked
  wire [31:0] ctrl_g = unlock ? ctrl_w
                              : {ctrl_w[31:16], ctrl_r[CCA_ON_BIT], ctrl_w[14:0]}; // [RQ17]
  wire [31:0] alm_w = alias_apply(alm_r, pwdata_i, op) & CCA_ALM_WMASK; // [RQ14]
  // Initial pulse level is frozen while the alarm is armed
  wire [31:0] alm_g = alm_en ? {alm_w[31:14], alm_r[CCA_PIV_BIT], alm_w[12:0]} : alm_w;
  wire [31:0] alm_base = wr_alm ? alm_g : alm_r;
  wire [7:0] alarm_repeat_count = alm_base[7:0];

  always_comb
  begin
    ctrl_nxt = wr_ctrl ? ctrl_g : ctrl_r;
    alm_nxt = alm_base;
    // The hardware event acts on top of a same-cycle write so no event is lost
    if (alarm_evt)
    begin
      if (alarm_repeat_count != 8'h00)
      begin
        alm_nxt[7:0] = alarm_repeat_count - 8'h01; // [RQ6]
      end
      else if (alm_base[CCA_CHIME_BIT])
      begin
        alm_nxt[7:0] = 8'hFF; // [RQ7]
      end
      else
      begin
        alm_nxt[CCA_ALM_EN_BIT] = 1'b0; // [RQ6] [RQ20]
      end
    end
    if (wr_time)
    begin
      time_nxt = alias_apply(time_r, pwdata_i, op) & CCA_TIME_MASK; // [RQ14]
    end
    else if (sec_step)
    begin
      time_nxt = time_adv;
    end
    else
    begin
      time_nxt = time_r;
    end
    if (wr_date)
    begin
      date_nxt = alias_apply(date_r, pwdata_i, op) & CCA_DATE_MASK;
    end
    else if (sec_step & day_carry)
    begin
      date_nxt = date_adv; // [RQ3] [RQ21]
    end
    else
    begin
      date_nxt = date_r;
    end
    if (sec_write)
    begin
      presc_nxt = 16'sh0000;
    end
    else if (half_evt)
    begin
      presc_nxt = min_edge ? cal_sext : 16'sh0000; // [RQ9]
    end
    else if (run & tick)
    begin
      presc_nxt = presc_r + 16'sh0001;
    end
    else
    begin
      presc_nxt = presc_r;
    end
  end

  // ****************************************
  // Output pin selection
  // ****************************************
  wire [1:0] osel = ctrl_r[CCA_OSEL_LSB +: 2];
  wire pin_nxt = (osel == CCA_OSEL_ALARM) ? pulse_r :
                 (osel == CCA_OSEL_SECONDS) ? half_r :
                 (osel == CCA_OSEL_TIMEBASE) ? tb_s2_r : 1'b0; // [RQ8]
  wire pulse_nxt = !alm_nxt[CCA_ALM_EN_BIT] ? alm_nxt[CCA_PIV_BIT] :
                   (alarm_evt ? ~pulse_r : pulse_r);

  // ****************************************
  // Read data
  // ****************************************
  wire [31:0] ctrl_rd = ctrl_r | ({31'h0, run} << CCA_RUNNING_BIT)
                               | ({31'h0, roll_warn} << CCA_ROLL_WARN_BIT)
                               | ({31'h0, half_r} << CCA_HALF_BIT); // [RQ2] [RQ15]
  wire [31:0] alm_rd = (alm_en ? {alm_r[31:14], pulse_r, alm_r[12:0]} : alm_r)
                       | ({31'h0, roll_warn} << CCA_ALM_WARN_BIT);
  wire [31:0] rd_val = hit_ctrl ? ctrl_rd :
                       hit_alm ? alm_rd :
                       hit_time ? time_r :
                       hit_date ? date_r :
                       hit_atime ? alm_time_r :
                       hit_adate ? alm_date_r : 32'h0000_0000;

  assign prdata_o = prdata_r;
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i & penable_i & ~hit_any;
  assign calendar_pin_o = pin_r;
  assign calendar_pin_oe_o = ctrl_r[CCA_PIN_OE_BIT] & on;

  // ****************************************
  // Flip-flops
  // ****************************************
  // Timebase pin is asynchronous; third stage only feeds the edge detector
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      tb_s1_r <= 1'b0;
      tb_s2_r <= 1'b0;
      tb_s3_r <= 1'b0;
    end
    else
    begin
      tb_s1_r <= timebase_clk_i;
      tb_s2_r <= tb_s1_r;
      tb_s3_r <= tb_s2_r;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      ctrl_r <= CCA_CTRL_RST; // [RQ15]
      alm_r <= CCA_ALM_RST; // [RQ15]
      time_r <= CCA_VALUE_RST;
      date_r <= CCA_VALUE_RST;
      alm_time_r <= CCA_VALUE_RST;
      alm_date_r <= CCA_VALUE_RST;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      alm_r <= alm_nxt;
      time_r <= time_nxt;
      date_r <= date_nxt;
      if (wr_atime)
      begin
        alm_time_r <= alias_apply(alm_time_r, pwdata_i, op) & CCA_TIME_MASK;
      end
      if (wr_adate)
      begin
        alm_date_r <= alias_apply(alm_date_r, pwdata_i, op) & CCA_ALM_DATE_MASK;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      presc_r <= 16'sh0000;
      half_r <= 1'b0;
      alm_chk_r <= 1'b0;
      pulse_r <= 1'b0;
      pin_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end
    else
    begin
      presc_r <= presc_nxt;
      half_r <= sec_write ? 1'b0 : (half_evt ? ~half_r : half_r); // [RQ2]
      alm_chk_r <= half_evt;
      pulse_r <= pulse_nxt;
      pin_r <= pin_nxt;
      if (rd_setup)
      begin
        prdata_r <= rd_val;
      end
    end
  end
endmodule
`default_nettype wire

// *** src/cca_pkg.sv ***
// Constants, register map and field layout of the calendar clock unit
// Operation
// RQ1: Time counts hours, minutes, seconds, 24-hour wrap
// RQ2: Software sees first or second half-second
// RQ3: Weekday, day, month, year 00-99, leap February
// RQ4: All values kept as packed BCD digits
// RQ5: Alarm intervals from half second to year
// RQ6: Repeat counter decrements; exhausted alarm stops
// RQ7: Chime wraps repeat counter, alarm never stops
// RQ8: Pin carries alarm pulse or seconds clock
// RQ9: Calibration is signed 10-bit count per minute
// RQ10: Positive calibration adds pulses, zero does nothing
// RQ11: Negative calibration removes up to 512 pulses
// RQ12: Clock runs only while enable bit set
// RQ13: Halt-in-idle stops clock during processor idle
// RQ14: Clear, set, invert aliases at +4, +8, +C
// RQ15: Controls reset zero, unimplemented bits read zero; control bits 9 and 10 are writable and read back
// RQ16: Calibration covers 260 ppm crystal error
// RQ17: Enable bit writable only while unlocked
// RQ18: Locked value registers ignore software writes
// RQ19: Four-bit interval mask; codes ten upward reserved
// RQ20: Hardware clears alarm enable when count exhausted
// RQ21: Digits carry upward through every calendar field
`default_nettype none
package cca_pkg;
  // ****************************************
  // Register offsets and alias operations
  // ****************************************
  localparam logic [11:0] CCA_CTRL_OFS = 12'h200;
  localparam logic [11:0] CCA_ALM_CTRL_OFS = 12'h210;
  localparam logic [11:0] CCA_TIME_OFS = 12'h220;
  localparam logic [11:0] CCA_DATE_OFS = 12'h230;
  localparam logic [11:0] CCA_ALM_TIME_OFS = 12'h240;
  localparam logic [11:0] CCA_ALM_DATE_OFS = 12'h250;
  localparam logic [1:0] CCA_OP_WRITE = 2'h0;
  localparam logic [1:0] CCA_OP_CLR = 2'h1;
  localparam logic [1:0] CCA_OP_SET = 2'h2;
  localparam logic [1:0] CCA_OP_INV = 2'h3;
  // ****************************************
  // Writable masks and reset values
  // ****************************************
  localparam logic [31:0] CCA_CTRL_WMASK = 32'h03FF_A789;
  localparam logic [31:0] CCA_ALM_WMASK = 32'h0000_EFFF;
  localparam logic [31:0] CCA_TIME_MASK = 32'h3F7F_7F00;
  localparam logic [31:0] CCA_DATE_MASK = 32'hFF1F_3F07;
  localparam logic [31:0] CCA_ALM_DATE_MASK = 32'h001F_3F07;
  localparam logic [31:0] CCA_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] CCA_ALM_RST = 32'h0000_0000;
  localparam logic [31:0] CCA_VALUE_RST = 32'h0000_0000;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int CCA_CAL_LSB = 16;
  localparam int CCA_ON_BIT = 15;
  localparam int CCA_HALT_IDLE_BIT = 13;
  localparam int CCA_OSEL_LSB = 7;
  localparam int CCA_RUNNING_BIT = 6;
  localparam int CCA_UNLOCK_BIT = 3;
  localparam int CCA_ROLL_WARN_BIT = 2;
  localparam int CCA_HALF_BIT = 1;
  localparam int CCA_PIN_OE_BIT = 0;
  localparam int CCA_ALM_EN_BIT = 15;
  localparam int CCA_CHIME_BIT = 14;
  localparam int CCA_PIV_BIT = 13;
  localparam int CCA_ALM_WARN_BIT = 12;
  localparam int CCA_ALARM_INTERVAL_MASK_LSB = 8;
  // ****************************************
  // Timebase and output select codes
  // ****************************************
  localparam int CCA_TB_HZ = 32768;
  localparam int CCA_HALF_TICKS = CCA_TB_HZ / 2;
  localparam int CCA_WARN_TICKS = 32;
  localparam logic [1:0] CCA_OSEL_ALARM = 2'h0;
  localparam logic [1:0] CCA_OSEL_SECONDS = 2'h1;
  localparam logic [1:0] CCA_OSEL_TIMEBASE = 2'h2;
endpackage
`default_nettype wire
